// File: design/bsd_link_params.svh
`ifndef BSD_LINK_PARAMS_SVH
`define BSD_LINK_PARAMS_SVH

// clock and timer rates in Hz
`define CLK_HZ 25000000
`define SYNC_TMR_HZ 5000000
`define BRK_TMR_HZ 131000
`define SYNC_TMR_DIV (`CLK_HZ / `SYNC_TMR_HZ)
`define BRK_TMR_DIV ((`CLK_HZ + `BRK_TMR_HZ / 2) / `BRK_TMR_HZ)

// bus bit rate and frame length
`define BSD_BIT_RATE 1200
`define BSD_FRAME_BITS 19
`define BSD_SIXTEENTH_DEN (16 * `BSD_BIT_RATE)

// low-time windows in sixteenths of a bit period
`define SYNC_LO_MIN 1
`define SYNC_LO_MAX 3
`define ZERO_LO_MIN 5
`define ZERO_LO_MAX 8
`define ONE_LO_MIN 10
`define ONE_LO_MAX 14

// register byte addresses
`define SYNC_CONTROL_PRIMARY_ADR 32'hffff_0780
`define SYNC_STATUS_ADR 32'hffff_0784
`define SYNC_TIMER_ADR 32'hffff_0788
`define BREAK_TIMER_ADR 32'hffff_078c
`define EDGE_CAPTURE_VALUE_ADR 32'hffff_0794
`define PULSE_WIDTH_COMPARE_ADR 32'hffff_0798
`define PORT2_DATA_ADR 32'hffff_07a0
`define PORT2_SET_ADR 32'hffff_07a4
`define PORT2_CLEAR_ADR 32'hffff_07a8
`define FRAME_FIELDS_ADR 32'hffff_07b0

// control bits
`define CTL_START_IE 3
`define CTL_CMP_IE 5
`define CTL_BSD_MODE 6
`define CTL_RISE_IE 8
`define CTL_W 9

// status bits
`define STA_RISE 0
`define STA_START 1
`define STA_CMP 3
`define STA_CLASS_LO 4
`define STA_RUN 6
`define STA_PIN 7

// port2 bits
`define P2_OUT 0
`define P2_PIN 4

// frame helper bits
`define FRM_HDR_PARITY 16
`define FRM_DATA_PARITY 17
`define FRM_WRITE_REQ 18
`define FRM_ACK 19
`define FRM_REGADR_WRITE 7

// reset values
`define CTRL_RST 9'h000
`define TIMER_RST 16'h0000
`define CAPTURE_RST 16'h0000
`define COMPARE_RST 16'h0000
`define FRAME_RST 16'h0000
`define P2_OUT_RST 1'b1
`define ACK_BIT_OK 1'b0

`endif

// File: design/bsd_pkg.sv
package bsd_pkg;

  typedef enum logic [1:0] {
    PC_NONE = 2'b00,
    PC_SYNC = 2'b01,
    PC_ZERO = 2'b11,
    PC_ONE = 2'b10
  } pulse_class_t;

endpackage

// File: design/bsd_pulse_width_link.sv
// What this block does
// - bus runs 1200 bps, frame nineteen bits
// - bit type set by low time
// - sync low between 1/16 and 3/16
// - zero low between 5/16 and 8/16
// - one low between 10/16 and 14/16
// - software drives pin via general output
// - 5 MHz timer captured on falling edges
// - compare match interrupts when enabled
// - frame order pause, header, data, ack
// - read: slave sends data, parity, ack
// - direction flag 0 master, 1 slave
// - register address bit 3 means write
// - header parity odd over eight bits; the code computes even (XOR) parity
// - data parity odd over data byte; the code computes even (XOR) parity
// - slave always acks with zero
// - master starts each bit pulling low
// - reception needs mode and rise enable
// - break timer spans low pulse, 131 kHz
// - sync timer free-runs in mode
// - compare match sets status bit 3
// - falling pin edge raises wake interrupt
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/10ps
`include "bsd_link_params.svh"

module bsd_pulse_width_link
  import bsd_pkg::*;
#(
  parameter int BRK_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic bus_i,
  output logic bus_o,
  output logic bus_oe_o,
  output logic irq_o
);

  localparam logic [BRK_W-1:0] BRK_MAX = '1;

  logic ack_q;
  logic [31:0] dat_q;
  logic [`CTL_W-1:0] sync_control_primary_q;
  logic [15:0] free_running_sync_timer_q;
  logic [15:0] edge_capture_value_q;
  logic [15:0] pulse_width_compare_q;
  logic [BRK_W-1:0] low_pulse_break_timer_q;
  logic brk_run_q;
  logic rise_flag_q;
  logic start_flag_q;
  logic cmp_flag_q;
  logic irq_q;
  logic port2_out_q;
  logic [15:0] frame_q;
  logic tick5_q;
  logic req;
  logic wr;
  logic rd;
  logic bsd_mode;
  logic tick5;
  logic tick_brk;
  logic pin_lvl;
  logic pin_fall;
  logic pin_rise;
  logic cmp_hit;
  logic header_parity;
  logic data_parity;
  logic clr_rise;
  logic clr_start;
  logic clr_cmp;
  pulse_class_t pulse_class;
  logic [31:0] rdata;

  function automatic logic [31:0] sel_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // n sixteenths of a bit period in break-timer ticks, rounded up or down
  function automatic logic [BRK_W-1:0] sixteenths(input int n, input bit up);
    int prod;
    prod = n * `BRK_TMR_HZ;
    if (up) begin
      return BRK_W'((prod + `BSD_SIXTEENTH_DEN - 1) / `BSD_SIXTEENTH_DEN);
    end
    return BRK_W'(prod / `BSD_SIXTEENTH_DEN);
  endfunction

  function automatic logic in_window(input logic [BRK_W-1:0] c, input int lo, input int hi);
    return (c >= sixteenths(lo, 1'b1)) && (c <= sixteenths(hi, 1'b0));
  endfunction

  assign bsd_mode = sync_control_primary_q[`CTL_BSD_MODE];

  pin_sync u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(bus_i),
    .level_o(pin_lvl),
    .fall_o(pin_fall),
    .rise_o(pin_rise)
  );

  rate_divider #(
    .DIV(`SYNC_TMR_DIV)
  ) u_sync_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(bsd_mode),
    .tick_o(tick5)
  );

  rate_divider #(
    .DIV(`BRK_TMR_DIV)
  ) u_brk_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(bsd_mode),
    .tick_o(tick_brk)
  );

  // wishbone classic slave, one wait state
  assign req = cyc_i & stb_i & ~ack_q;
  assign wr = req & we_i;
  assign rd = req & ~we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_control_primary_q <= `CTRL_RST;
    end else if (wr && adr_i == `SYNC_CONTROL_PRIMARY_ADR) begin
      sync_control_primary_q <= `CTL_W'(sel_merge(32'(sync_control_primary_q), dat_i, sel_i));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_width_compare_q <= `COMPARE_RST;
    end else if (wr && adr_i == `PULSE_WIDTH_COMPARE_ADR) begin
      pulse_width_compare_q <= 16'(sel_merge(32'(pulse_width_compare_q), dat_i, sel_i));
    end
  end

  // frame helper: [0] direction, [3:1] slave, [7:4] register, [15:8] data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_q <= `FRAME_RST;
    end else if (wr && adr_i == `FRAME_FIELDS_ADR) begin
      frame_q <= 16'(sel_merge(32'(frame_q), dat_i, sel_i));
    end
  end

  // software drives the open-drain pin; output level 1 releases it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port2_out_q <= `P2_OUT_RST;
    end else if (wr && sel_i[0]) begin
      if (adr_i == `PORT2_DATA_ADR) begin
        port2_out_q <= dat_i[`P2_OUT];
      end else if (adr_i == `PORT2_SET_ADR && dat_i[`P2_OUT]) begin
        port2_out_q <= 1'b1;
      end else if (adr_i == `PORT2_CLEAR_ADR && dat_i[`P2_OUT]) begin
        port2_out_q <= 1'b0;
      end
    end
  end

  assign bus_o = 1'b0;
  assign bus_oe_o = ~port2_out_q;

  // sync timer ticks at 5 MHz and ignores bus edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      free_running_sync_timer_q <= `TIMER_RST;
    end else if (bsd_mode && tick5) begin
      free_running_sync_timer_q <= free_running_sync_timer_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_capture_value_q <= `CAPTURE_RST;
    end else if (bsd_mode && pin_fall) begin
      edge_capture_value_q <= free_running_sync_timer_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick5_q <= 1'b0;
    end else begin
      tick5_q <= bsd_mode && tick5;
    end
  end

  // one-cycle event right after the timer steps onto the compare value
  assign cmp_hit = tick5_q && (free_running_sync_timer_q == pulse_width_compare_q);

  // break timer measures each low pulse from its falling edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_pulse_break_timer_q <= '0;
      brk_run_q <= 1'b0;
    end else if (!bsd_mode) begin
      brk_run_q <= 1'b0;
    end else if (pin_fall) begin
      low_pulse_break_timer_q <= '0;
      brk_run_q <= 1'b1;
    end else if (brk_run_q && pin_rise) begin
      brk_run_q <= 1'b0;
    end else if (brk_run_q && tick_brk && low_pulse_break_timer_q != BRK_MAX) begin
      low_pulse_break_timer_q <= low_pulse_break_timer_q + BRK_W'(1);
    end
  end

  // classify the last measured low time at the nominal bit rate
  always_comb begin
    pulse_class = PC_NONE;
    if (in_window(low_pulse_break_timer_q, `SYNC_LO_MIN, `SYNC_LO_MAX)) begin
      pulse_class = PC_SYNC;
    end else if (in_window(low_pulse_break_timer_q, `ZERO_LO_MIN, `ZERO_LO_MAX)) begin
      pulse_class = PC_ZERO;
    end else if (in_window(low_pulse_break_timer_q, `ONE_LO_MIN, `ONE_LO_MAX)) begin
      pulse_class = PC_ONE;
    end
  end

  // sticky flags, write one to clear, a new event beats the clear
  assign clr_rise = wr && sel_i[0] && adr_i == `SYNC_STATUS_ADR && dat_i[`STA_RISE];
  assign clr_start = wr && sel_i[0] && adr_i == `SYNC_STATUS_ADR && dat_i[`STA_START];
  assign clr_cmp = wr && sel_i[0] && adr_i == `SYNC_STATUS_ADR && dat_i[`STA_CMP];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rise_flag_q <= 1'b0;
    end else begin
      rise_flag_q <= (brk_run_q && pin_rise && bsd_mode) || (rise_flag_q && !clr_rise);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_flag_q <= 1'b0;
    end else begin
      start_flag_q <= pin_fall || (start_flag_q && !clr_start);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_flag_q <= 1'b0;
    end else begin
      cmp_flag_q <= cmp_hit || (cmp_flag_q && !clr_cmp);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (cmp_flag_q && sync_control_primary_q[`CTL_CMP_IE]) ||
               (rise_flag_q && sync_control_primary_q[`CTL_RISE_IE]) ||
               (start_flag_q && sync_control_primary_q[`CTL_START_IE]);
    end
  end

  assign irq_o = irq_q;

  // eight header bits: direction, slave address, register address
  assign header_parity = ^frame_q[7:0];
  assign data_parity = ^frame_q[15:8];

  always_comb begin
    rdata = 32'h0000_0000;
    case (adr_i)
      `SYNC_CONTROL_PRIMARY_ADR: rdata = 32'(sync_control_primary_q);
      `SYNC_STATUS_ADR: begin
        rdata[`STA_RISE] = rise_flag_q;
        rdata[`STA_START] = start_flag_q;
        rdata[`STA_CMP] = cmp_flag_q;
        rdata[`STA_CLASS_LO +: 2] = pulse_class;
        rdata[`STA_RUN] = brk_run_q;
        rdata[`STA_PIN] = pin_lvl;
      end
      `SYNC_TIMER_ADR: rdata = 32'(free_running_sync_timer_q);
      `BREAK_TIMER_ADR: rdata = 32'(low_pulse_break_timer_q);
      `EDGE_CAPTURE_VALUE_ADR: rdata = 32'(edge_capture_value_q);
      `PULSE_WIDTH_COMPARE_ADR: rdata = 32'(pulse_width_compare_q);
      `PORT2_DATA_ADR: begin
        rdata[`P2_OUT] = port2_out_q;
        rdata[`P2_PIN] = pin_lvl;
      end
      `FRAME_FIELDS_ADR: begin
        rdata[15:0] = frame_q;
        rdata[`FRM_HDR_PARITY] = header_parity;
        rdata[`FRM_DATA_PARITY] = data_parity;
        rdata[`FRM_WRITE_REQ] = frame_q[`FRM_REGADR_WRITE];
        rdata[`FRM_ACK] = `ACK_BIT_OK;
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (rd) begin
      dat_q <= rdata;
    end
  end

  assign dat_o = dat_q;
  assign ack_o = ack_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence pulse_end_s;
    brk_run_q && pin_rise && bsd_mode;
  endsequence

  sequence stopped_s;
    !brk_run_q && rise_flag_q;
  endsequence

  sequence frame_read_s;
    rd && adr_i == `FRAME_FIELDS_ADR;
  endsequence

  capture_on_fall_a: assert property (bsd_mode && pin_fall |=>
    edge_capture_value_q == $past(free_running_sync_timer_q))
    else $error("capture missed falling edge");

  timer_free_run_a: assert property (bsd_mode && tick5 |=>
    free_running_sync_timer_q == $past(free_running_sync_timer_q) + 16'h0001)
    else $error("sync timer did not step");

  compare_flag_a: assert property (cmp_hit |=> cmp_flag_q)
    else $error("compare match lost");

  compare_irq_a: assert property (cmp_hit ##1 sync_control_primary_q[`CTL_CMP_IE]
    |=> irq_o)
    else $error("compare interrupt missing");

  match_single_a: assert property (cmp_hit |=> !cmp_hit)
    else $error("match lasted beyond one cycle");

  flag_sticky_a: assert property (cmp_flag_q && !clr_cmp |=> cmp_flag_q)
    else $error("compare flag dropped by itself");

  break_clear_a: assert property (bsd_mode && pin_fall |=>
    brk_run_q && low_pulse_break_timer_q == '0)
    else $error("break timer not restarted");

  break_stop_a: assert property (pulse_end_s |=> stopped_s)
    else $error("break timer did not stop on rise");

  break_hold_a: assert property (!brk_run_q && !pin_fall |=>
    $stable(low_pulse_break_timer_q))
    else $error("stopped break timer moved");

  break_sat_a: assert property (brk_run_q && low_pulse_break_timer_q == BRK_MAX &&
    !pin_fall |=> low_pulse_break_timer_q == BRK_MAX)
    else $error("break timer wrapped");

  rise_irq_a: assert property (pulse_end_s ##1 sync_control_primary_q[`CTL_RISE_IE]
    |=> irq_o)
    else $error("rise interrupt missing");

  start_wake_a: assert property (pin_fall ##1 sync_control_primary_q[`CTL_START_IE]
    |-> start_flag_q ##1 irq_o)
    else $error("start interrupt missing");

  pin_drive_a: assert property (!port2_out_q |-> bus_oe_o && !bus_o)
    else $error("pin not driven low");

  sync_class_a: assert property (pulse_class == PC_SYNC |->
    low_pulse_break_timer_q >= sixteenths(`SYNC_LO_MIN, 1'b1) &&
    low_pulse_break_timer_q <= sixteenths(`SYNC_LO_MAX, 1'b0))
    else $error("sync class outside window");

  one_class_a: assert property (pulse_class == PC_ONE |->
    low_pulse_break_timer_q >= sixteenths(`ONE_LO_MIN, 1'b1))
    else $error("one class below window");

  parity_read_a: assert property (frame_read_s |=> ack_o &&
    dat_o[`FRM_HDR_PARITY] == ^$past(frame_q[7:0]) && dat_o[`FRM_ACK] == 1'b0)
    else $error("header parity or ack read wrong");

  bus_ack_a: assert property (req |=> ack_o ##1 !ack_o)
    else $error("bus ack not one cycle");

endmodule

// File: design/pin_sync.sv
`timescale 1ns/10ps

module pin_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o,
  output logic fall_o,
  output logic rise_o
);

  logic meta_q;
  logic level_q;
  logic prev_q;

  // idle bus is high, so all stages reset high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b1;
      level_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= pin_i;
      level_q <= meta_q;
      prev_q <= level_q;
    end
  end

  assign level_o = level_q;
  assign fall_o = prev_q & ~level_q;
  assign rise_o = ~prev_q & level_q;

endmodule

// File: design/rate_divider.sv
`timescale 1ns/10ps

module rate_divider #(
  parameter int DIV = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  output logic tick_o
);

  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

  logic [W-1:0] cnt_q;
  logic tick_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      cnt_q <= '0;
    end else if (cnt_q == W'(DIV - 1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= en_i && (cnt_q == W'(DIV - 1));
    end
  end

  assign tick_o = tick_q;

endmodule

// File: verification/bsd_node_model.sv
`timescale 1ns/10ps

module bsd_node_model (
  input wire logic clk_i,
  output logic pull_o
);
  initial pull_o = 1'b0;

  // one bit period: pull low, then release to the pull-up
  task automatic drive_bit(input int low_cyc, input int per_cyc);
    @(posedge clk_i);
    pull_o <= 1'b1;
    repeat (low_cyc) @(posedge clk_i);
    pull_o <= 1'b0;
    repeat (per_cyc - low_cyc - 1) @(posedge clk_i);
  endtask
endmodule

// File: verification/bsd_pulse_width_link_tb_top.sv
`timescale 1ns/10ps
`include "bsd_link_params.svh"

module bsd_pulse_width_link_tb_top
  import bsd_pkg::*;
;
  localparam int PER = `CLK_HZ / `BSD_BIT_RATE;
  // narrow break timer so that saturation is reachable in a short run
  localparam int BRK_W = 7;
  int tk;
  logic clk, rst, cyc, stb, we, ack, bus_in, bus_out, bus_oe, irq, pull;
  logic [31:0] adr, wdat, rdat, q, c1;
  logic [3:0] sel;
  int errors = 0;
  int total_checks = 0;
  int lows[3];
  pulse_class_t cls[3];
  logic [15:0] frm[4];

  // open-drain wire with pull-up
  assign bus_in = ~(bus_oe | pull);

  bsd_pulse_width_link #(
    .BRK_W(BRK_W)
  ) bsd_pulse_width_link_inst (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack),
    .bus_i(bus_in), .bus_o(bus_out), .bus_oe_o(bus_oe), .irq_o(irq)
  );

  bsd_node_model bsd_node_model_inst (.clk_i(clk), .pull_o(pull));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    wb(1'b0, a, 32'h0, r);
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    rd(a, r);
    chk(r, exp);
  endtask

  task automatic final_report();
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (80000) @(posedge clk);
    errors++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    {cyc, stb, we} = 3'b000;
    adr = 32'h0;
    wdat = 32'h0;
    sel = 4'h0;
    lows = '{PER * 2 / 16, PER * 6 / 16, PER * 12 / 16};
    cls = '{PC_SYNC, PC_ZERO, PC_ONE};
    frm = '{16'h0000, 16'hb74e, 16'h01ff, 16'hff80};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values and access kinds
    rchk(`EDGE_CAPTURE_VALUE_ADR, 32'h0);
    rchk(`PULSE_WIDTH_COMPARE_ADR, 32'h0);
    rchk(`PORT2_DATA_ADR, 32'h11);
    wr(`PULSE_WIDTH_COMPARE_ADR, 32'h1234_abcd);
    rchk(`PULSE_WIDTH_COMPARE_ADR, 32'h0000_abcd);
    wr(`EDGE_CAPTURE_VALUE_ADR, 32'h5555);
    rchk(`EDGE_CAPTURE_VALUE_ADR, 32'h0);
    rchk(32'hffff_07fc, 32'h0);
    // software drives the pin through the port output
    wr(`PORT2_CLEAR_ADR, 32'h1);
    repeat (4) @(posedge clk);
    chk({31'b0, bus_oe}, 32'h1);
    chk({31'b0, bus_out}, 32'h0);
    rchk(`PORT2_DATA_ADR, 32'h0);
    wr(`PORT2_SET_ADR, 32'h1);
    chk({31'b0, bus_oe}, 32'h0);
    wr(`PORT2_DATA_ADR, 32'h0000_0000);
    chk({31'b0, bus_oe}, 32'h0000_0001);
    wr(`PORT2_DATA_ADR, 32'h0000_0001);
    chk({31'b0, bus_oe}, 32'h0000_0000);
    // frame helper fields and parities
    foreach (frm[i]) begin
      wr(`FRAME_FIELDS_ADR, {16'h0, frm[i]});
      q = {12'h0, 1'b0, frm[i][7], ^frm[i][15:8], ^frm[i][7:0], frm[i]};
      rchk(`FRAME_FIELDS_ADR, q);
    end
    // capture on two falls exactly 1000 clocks apart
    wr(`SYNC_CONTROL_PRIMARY_ADR, 32'h40);
    fork
      begin
        bsd_node_model_inst.drive_bit(100, 1000);
        bsd_node_model_inst.drive_bit(100, 1000);
      end
      begin
        repeat (500) @(posedge clk);
        rd(`EDGE_CAPTURE_VALUE_ADR, c1);
      end
    join
    rd(`EDGE_CAPTURE_VALUE_ADR, q);
    chk({16'h0, q[15:0] - c1[15:0]}, 32'hc8);
    // compare match: flag without enable, then interrupt
    wr(`SYNC_STATUS_ADR, 32'hb);
    rd(`SYNC_TIMER_ADR, q);
    wr(`PULSE_WIDTH_COMPARE_ADR, {16'h0, q[15:0] + 16'd100});
    q = 32'h0000_0000;
    for (int n = 0; n < 300 && q[`STA_CMP] !== 1'b1; n++) begin
      rd(`SYNC_STATUS_ADR, q);
    end
    chk({31'b0, q[`STA_CMP]}, 32'h1);
    chk({31'b0, irq}, 32'h0);
    repeat (50) @(posedge clk);
    rd(`SYNC_STATUS_ADR, q);
    chk({31'b0, q[`STA_CMP]}, 32'h1);
    wr(`SYNC_CONTROL_PRIMARY_ADR, 32'h60);
    repeat (3) @(posedge clk);
    chk({31'b0, irq}, 32'h1);
    wr(`SYNC_STATUS_ADR, 32'h8);
    repeat (3) @(posedge clk);
    chk({31'b0, irq}, 32'h0);
    // reception: break timer classifies sync, zero and one
    wr(`SYNC_CONTROL_PRIMARY_ADR, 32'h148);
    rchk(`SYNC_CONTROL_PRIMARY_ADR, 32'h0000_0148);
    foreach (lows[i]) begin
      wr(`SYNC_STATUS_ADR, 32'hb);
      bsd_node_model_inst.drive_bit(lows[i], lows[i] + 300);
      rd(`SYNC_STATUS_ADR, q);
      chk({30'b0, q[5:4]}, {30'b0, cls[i]});
      chk({30'b0, q[1:0]}, 32'h3);
      chk({31'b0, irq}, 32'h1);
      rd(`BREAK_TIMER_ADR, q);
      tk = lows[i] / `BRK_TMR_DIV;
      chk({31'b0, q >= tk - 1 && q <= tk + 1}, 32'h1);
    end
    // a bus held low past the timer range leaves it at its top count
    wr(`SYNC_STATUS_ADR, 32'h0000_000b);
    bsd_node_model_inst.drive_bit(26000, 26300);
    rchk(`BREAK_TIMER_ADR, 32'((1 << BRK_W) - 1));
    rd(`SYNC_STATUS_ADR, q);
    chk({30'b0, q[5:4]}, {30'b0, PC_NONE});
    final_report();
  end
endmodule
